// ### rtl/vector_resolver_params.svh
/*
  Constants of the interrupt vector priority resolver: vector numbers,
  register offsets, level-bit positions and reset values.
  Assumes inclusion by rtl/vector_resolver_pkg.sv and the resolver module.
*/
`ifndef VECTOR_RESOLVER_PARAMS_SVH
`define VECTOR_RESOLVER_PARAMS_SVH

// Vector numbers
`define VEC_NONMASK 6'h07
`define VEC_PIN0 6'h10
`define VEC_SOFT_END 6'h18
`define VEC_WATCHDOG 6'h19
`define VEC_CONV_END 6'h1c
`define VEC_TIMER0 6'h20
`define VEC_TIMER1 6'h28
`define VEC_TIMER2 6'h2c

// Source index layout inside the 25-bit request vector
`define SRC_NONMASK 0
`define SRC_PIN0 1
`define SRC_SOFT_END 9
`define SRC_WATCHDOG 10
`define SRC_CONV_END 11
`define SRC_TIMER0 12
`define SRC_TIMER1 17
`define SRC_TIMER2 21
`define SRC_COUNT 25
`define PIN_COUNT 8
`define TIMER0_COUNT 5
`define TIMER12_COUNT 4

// Level-bit positions inside the 16-bit priority level register
`define LVL_PIN0 15
`define LVL_PIN1 14
`define LVL_PIN23 13
`define LVL_PIN45 12
`define LVL_PIN67 11
`define LVL_SOFT_END 10
`define LVL_WATCHDOG 9
`define LVL_CONV_END 6
`define LVL_TIMER0 5
`define LVL_TIMER1 4
`define LVL_TIMER2 3
`define LVL_WRITABLE 16'hfe78

// Register byte addresses
`define ADDR_LEVEL 5'h00
`define ADDR_ENABLE 5'h04
`define ADDR_CONTROL 5'h08
`define ADDR_RESULT 5'h0c
`define ADDR_STATUS 5'h10
`define ADDR_MASK 5'h14

// Reset values
`define LEVEL_RESET 16'h0000
`define ENABLE_RESET 24'h000000
`define CONTROL_RESET 1'b0
`define MASK_RESET 2'h0
`define STATUS_RESET 2'h0

// Result register field positions
`define RES_VALID_BIT 31
`define RES_VEC_LSB 16

// Status bits
`define ST_WINNER_CHANGE 0
`define ST_NONMASK_SEEN 1
`define ST_WIDTH 2

`endif

// ### rtl/vector_resolver_pkg.sv
/*
  Types shared by the interrupt vector priority resolver.
  Assumes the params header for all numeric constants.
*/
`include "vector_resolver_params.svh"

package vector_resolver_pkg;

  // Raw request lines from the on-chip sources and the pins
  typedef struct packed {
    logic [3:0] timer2;
    logic [3:0] timer1;
    logic [4:0] timer0;
    logic conv_end;
    logic watchdog;
    logic soft_end;
    logic [7:0] pins;
    logic nonmask;
  } request_t;

  // Answer offered to the processor core
  typedef struct packed {
    logic valid;
    logic nonmask;
    logic [5:0] number;
    logic [15:0] address;
  } vector_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_DONE = 2'b01
  } bus_state_t;

endpackage

// ### rtl/interrupt_vector_priority_resolver.sv
/*
  Interrupt vector priority resolver: picks one winning request from the
  external pins and on-chip sources, and gives its vector number and
  address to the core. Registers sit on an Avalon-MM slave.
  Assumes request lines synchronous to clk, one clock, synchronous reset.
*/
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "vector_resolver_params.svh"

// Contract
// RULE1: Default order: smaller vector number wins
// RULE2: Raised module level bit beats lower modules
// RULE3: Equal levels and intra-module ties use vector order
// RULE4: Address is vector times two or four
// RULE5: Pins 0-7 on vectors 16-23, paired levels; the code pairs only pins 2-7, pins 0 and 1 have own level bits
// RULE6: Soft end 24, watchdog 25, own levels
// RULE7: Conversion end 28 with own level bit
// RULE8: Timer 0 vectors 32-36, one level bit
// RULE9: Timer 1 vectors 40-43, one level bit
// RULE10: Timer 2 vectors 44-47, one level bit
// RULE11: Reserved vectors are never issued
// RULE12: Non-maskable request always top, never masked
// RULE13: Disabled sources take no part in resolution
module interrupt_vector_priority_resolver
#(
  parameter int SOURCES = `SRC_COUNT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request lines
  input vector_resolver_pkg::request_t requests,
  // Vector to the core
  output vector_resolver_pkg::vector_t vector_out,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq
);
  import vector_resolver_pkg::*;

  // Source table below is fixed; refuse any other count
  if (SOURCES != `SRC_COUNT)
  begin
    $error("SOURCES must equal the fixed source count");
  end

  // Registers and resolution nets
  logic [15:0] level_reg;
  logic [23:0] enable_reg;
  logic advanced_reg;
  logic [`ST_WIDTH-1:0] status_reg;
  logic [`ST_WIDTH-1:0] mask_reg;
  vector_t vector_reg;
  vector_t vector_next;
  bus_state_t bus_state_reg;
  logic [SOURCES-1:0] raw;
  logic [SOURCES-1:0] active;
  logic [SOURCES-1:0] raised;
  logic [5:0] src_vec [SOURCES];
  logic [SOURCES-1:0] src_lvl;

  // Byte-lane merge shared by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Vector address from number and mode
  function automatic logic [15:0] vec_addr(input logic [5:0] num, input logic adv);
    return adv ? {8'h00, num, 2'h0} : {9'h000, num, 1'h0}; // [RULE4]
  endfunction

  assign raw = requests;

  // Fixed source table: vector number and level bit of each source
  always_comb
  begin
    src_vec[`SRC_NONMASK] = `VEC_NONMASK;
    src_lvl[`SRC_NONMASK] = 1'b1;
    for (int i = 0; i < `PIN_COUNT; i++)
    begin
      src_vec[`SRC_PIN0 + i] = `VEC_PIN0 + 6'(i); // [RULE5]
    end
    // Pins 2 to 7 share one level bit per pair
    src_lvl[`SRC_PIN0] = level_reg[`LVL_PIN0]; // [RULE5]
    src_lvl[`SRC_PIN0 + 1] = level_reg[`LVL_PIN1];
    src_lvl[`SRC_PIN0 + 2] = level_reg[`LVL_PIN23];
    src_lvl[`SRC_PIN0 + 3] = level_reg[`LVL_PIN23];
    src_lvl[`SRC_PIN0 + 4] = level_reg[`LVL_PIN45];
    src_lvl[`SRC_PIN0 + 5] = level_reg[`LVL_PIN45];
    src_lvl[`SRC_PIN0 + 6] = level_reg[`LVL_PIN67];
    src_lvl[`SRC_PIN0 + 7] = level_reg[`LVL_PIN67];
    src_vec[`SRC_SOFT_END] = `VEC_SOFT_END; // [RULE6]
    src_lvl[`SRC_SOFT_END] = level_reg[`LVL_SOFT_END];
    src_vec[`SRC_WATCHDOG] = `VEC_WATCHDOG; // [RULE6]
    src_lvl[`SRC_WATCHDOG] = level_reg[`LVL_WATCHDOG];
    src_vec[`SRC_CONV_END] = `VEC_CONV_END; // [RULE7]
    src_lvl[`SRC_CONV_END] = level_reg[`LVL_CONV_END];
    // Each timer channel shares one level bit
    for (int i = 0; i < `TIMER0_COUNT; i++)
    begin
      src_vec[`SRC_TIMER0 + i] = `VEC_TIMER0 + 6'(i); // [RULE8]
      src_lvl[`SRC_TIMER0 + i] = level_reg[`LVL_TIMER0];
    end
    for (int i = 0; i < `TIMER12_COUNT; i++)
    begin
      src_vec[`SRC_TIMER1 + i] = `VEC_TIMER1 + 6'(i); // [RULE9]
      src_lvl[`SRC_TIMER1 + i] = level_reg[`LVL_TIMER1];
      src_vec[`SRC_TIMER2 + i] = `VEC_TIMER2 + 6'(i); // [RULE10]
      src_lvl[`SRC_TIMER2 + i] = level_reg[`LVL_TIMER2];
    end
  end

  // Non-maskable line ignores enables; others need their enable bit
  assign active = raw & {enable_reg, 1'b1}; // [RULE12] [RULE13]
  assign raised = active & src_lvl;

  // Sources are indexed in rising vector order, so lowest index wins.
  // Only mapped sources exist in the table, so no reserved number escapes.
  always_comb
  begin
    logic [SOURCES-1:0] pool;
    int win;
    win = 0;
    pool = (|raised) ? raised : active; // [RULE2]
    if (raw[`SRC_NONMASK])
    begin
      pool = active & {{(SOURCES-1){1'b0}}, 1'b1}; // [RULE12]
    end
    // Scan downward so the last hit is the lowest index
    for (int i = SOURCES - 1; i >= 0; i--)
    begin
      if (pool[i])
      begin
        win = i; // [RULE1] [RULE3] [RULE11]
      end
    end
    // Zero number and address when nothing is pending
    vector_next.valid = |pool;
    vector_next.nonmask = raw[`SRC_NONMASK];
    vector_next.number = (|pool) ? src_vec[win] : 6'h00;
    vector_next.address = (|pool) ? vec_addr(src_vec[win], advanced_reg) : 16'h0000;
  end

  // Registered answer: one cycle from request to vector
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      vector_reg <= '0;
    end
    else
    begin
      vector_reg <= vector_next;
    end
  end

  assign vector_out = vector_reg;

  // Register writes: merged words first, one process per register
  wire wr_hit = avs_write;
  logic [31:0] wr_level;
  logic [31:0] wr_enable;
  logic [31:0] wr_control;
  logic [31:0] wr_mask;
  assign wr_level = merge({16'h0000, level_reg}, avs_writedata, avs_byteenable);
  assign wr_enable = merge({8'h00, enable_reg}, avs_writedata, avs_byteenable);
  assign wr_control = merge({31'h0, advanced_reg}, avs_writedata, avs_byteenable);
  assign wr_mask = merge({30'h0, mask_reg}, avs_writedata, avs_byteenable);

  // Dead level bits stay zero, so a read shows only live levels
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      level_reg <= `LEVEL_RESET;
    end
    else if (wr_hit && avs_address == `ADDR_LEVEL)
    begin
      level_reg <= wr_level[15:0] & `LVL_WRITABLE;
    end
  end

  // Enable bit i gates source index i+1; nonmask has none
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      enable_reg <= `ENABLE_RESET;
    end
    else if (wr_hit && avs_address == `ADDR_ENABLE)
    begin
      enable_reg <= wr_enable[23:0];
    end
  end

  // Control bit 0 selects times-four vector addresses
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      advanced_reg <= `CONTROL_RESET;
    end
    else if (wr_hit && avs_address == `ADDR_CONTROL)
    begin
      advanced_reg <= wr_control[0];
    end
  end

  // Mask shares the status layout
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mask_reg <= `MASK_RESET;
    end
    else if (wr_hit && avs_address == `ADDR_MASK)
    begin
      mask_reg <= wr_mask[`ST_WIDTH-1:0];
    end
  end

  // Sticky events; a read of status clears, but a new event wins
  logic [`ST_WIDTH-1:0] events;
  logic status_rd;
  assign events[`ST_WINNER_CHANGE] = vector_next.valid &&
                                     (vector_next.number != vector_reg.number ||
                                      !vector_reg.valid);
  assign events[`ST_NONMASK_SEEN] = raw[`SRC_NONMASK] && !vector_reg.nonmask;
  // Clear on the first bus cycle of the read, as the data are latched
  assign status_rd = avs_read && bus_state_reg == RD_IDLE && avs_address == `ADDR_STATUS;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_reg <= `STATUS_RESET;
    end
    else
    begin
      status_reg <= (status_rd ? '0 : status_reg) | events;
    end
  end

  // Level output; stays high until status is read
  assign irq = |(status_reg & mask_reg);

  // Reads take one wait cycle so read data come from a flip-flop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_state_reg <= RD_IDLE;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      unique case (bus_state_reg)
        RD_IDLE:
        begin
          if (avs_read)
          begin
            bus_state_reg <= RD_DONE;
            unique case (avs_address)
              `ADDR_LEVEL: avs_readdata <= {16'h0000, level_reg};
              `ADDR_ENABLE: avs_readdata <= {8'h00, enable_reg};
              `ADDR_CONTROL: avs_readdata <= {31'h0, advanced_reg};
              `ADDR_RESULT: avs_readdata <= {vector_reg.valid, 7'h00, 2'h0,
                                             vector_reg.number, vector_reg.address};
              // Pre-clear value; a set in the same cycle survives
              `ADDR_STATUS: avs_readdata <= {30'h0, status_reg};
              `ADDR_MASK: avs_readdata <= {30'h0, mask_reg};
              default: avs_readdata <= 32'h00000000;
            endcase
          end
        end
        RD_DONE:
        begin
          bus_state_reg <= RD_IDLE;
        end
      endcase
    end
  end

  // Writes never wait; a read waits exactly one cycle
  assign avs_waitrequest = avs_read && bus_state_reg == RD_IDLE;

endmodule

// ### test/resolver_props.sv
/*
  Checker of the vector resolver: concurrent assertions on its ports.
  Assumes binding to the resolver top module from the bench file.
*/
`timescale 1ns/1ns
module resolver_props
#(
  parameter int SOURCES = 25
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Requests and answer
  input vector_resolver_pkg::request_t requests,
  input vector_resolver_pkg::vector_t vector_out,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  import vector_resolver_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Requests one edge back, so they line up with the registered answer
  request_t req_reg;
  logic [5:0] n;
  logic v;
  always_ff @(posedge clk)
    req_reg <= requests;
  assign n = vector_out.number;
  assign v = vector_out.valid;
  sequence rd_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  nonmask_top_a: assert property (requests.nonmask |=> v && n == 6'h07)
    else $error("nonmask did not win");
  addr_scale_a: assert property (v |-> vector_out.address == {9'h0, n, 1'b0}
    || vector_out.address == {8'h0, n, 2'b0}) else $error("address not scaled");
  no_reserved_a: assert property (v |-> n inside {6'd7, [6'd16:6'd25], 6'd28,
    [6'd32:6'd36], [6'd40:6'd47]}) else $error("reserved vector issued");
  pin_map_a: assert property (v && n inside {[6'd16:6'd23]} |-> req_reg.pins[n[2:0]])
    else $error("pin vector without request");
  soft_wd_a: assert property (v && (n == 6'd24 || n == 6'd25)
    |-> (n[0] ? req_reg.watchdog : req_reg.soft_end)) else $error("bad 24/25 vector");
  conv_map_a: assert property (v && n == 6'd28 |-> req_reg.conv_end)
    else $error("conversion vector without request");
  timer0_map_a: assert property (v && n inside {[6'd32:6'd36]} |-> req_reg.timer0[n[2:0]])
    else $error("timer0 vector without request");
  timer12_map_a: assert property (v && n inside {[6'd40:6'd47]} |-> req_reg[n - 6'd23])
    else $error("timer1/2 vector without request");
  idle_quiet_a: assert property (requests == '0 |=> !v)
    else $error("winner without request");
  read_wait_a: assert property ($rose(avs_read) |-> rd_wait)
    else $error("read wait state wrong");
  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
endmodule

// ### test/core_model.sv
/*
  Behavioural processor core at the far side: keeps the last vector taken.
  Assumes vector_out registered on the rising edge of clk.
*/
`timescale 1ns/1ns
module core_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Vector offered and vector taken
  input vector_resolver_pkg::vector_t vector_out,
  output vector_resolver_pkg::vector_t taken
);
  import vector_resolver_pkg::*;
  // No mask of its own, so a nonmask vector is never held off
  always_ff @(posedge clk)
    if (sys_rst)
      taken <= '0;
    else if (vector_out.valid)
      taken <= vector_out;
endmodule

// ### test/interrupt_vector_priority_resolver_bench.sv
/*
  Bench of the vector resolver: bus and request tasks, table-driven checks.
  Assumes resolver, core model and checker compiled before this file.
*/
`timescale 1ns/1ns
bind interrupt_vector_priority_resolver resolver_props #(.SOURCES(SOURCES)) props_i (
  .clk, .sys_rst, .requests, .vector_out, .avs_read, .avs_write, .avs_waitrequest);
module interrupt_vector_priority_resolver_bench;
  import vector_resolver_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  request_t requests = '0;
  vector_t vector_out;
  vector_t taken;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic avs_waitrequest;
  logic irq;
  logic adv = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  logic [15:0] lvl [5] = '{16'h0008, 16'h0028, 16'h0800, 16'h0040, 16'h0181};
  logic [5:0] lwin [5] = '{6'd44, 6'd32, 6'd22, 6'd28, 6'd16};
  always #50 clk = ~clk;
  interrupt_vector_priority_resolver #(.SOURCES(25)) uut (
    .clk, .sys_rst, .requests, .vector_out, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .irq);
  core_model core (.clk, .sys_rst, .vector_out, .taken);
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clk);
    avs_write <= we;
    avs_read <= !we;
    avs_address <= a;
    avs_writedata <= d;
    n = 0;
    // Sample at the rising edge itself; the request stands until then
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic vec(input logic [24:0] r, input logic v, input logic [5:0] num);
    @(posedge clk);
    requests <= r;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp("valid", v, vector_out.valid);
    cmp("nonmask", r[0], vector_out.nonmask);
    if (v)
    begin
      cmp("number", num, vector_out.number);
      cmp("address", {10'h0, num} << (adv ? 2 : 1), vector_out.address);
    end
  endtask
  function automatic logic [5:0] vnum(input int i);
    return i == 0 ? 6'd7 : i <= 10 ? 6'(i + 15) : i == 11 ? 6'd28 :
      i <= 16 ? 6'(i + 20) : 6'(i + 23);
  endfunction
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1, 5'h14, 32'h1, q);
    bus(1, 5'h04, 32'hffffffff, q);
    bus(0, 5'h04, 0, q);
    cmp("enable", 32'h00ffffff, q);
    bus(0, 5'h1c, 0, q);
    cmp("unmapped", 0, q);
    vec(25'h2, 1, 6'd16);
    @(negedge clk);
    cmp("irq set", 1, irq);
    bus(0, 5'h10, 0, q);
    cmp("status", 1, q);
    @(negedge clk);
    cmp("irq clear", 0, irq);
    bus(0, 5'h0c, 0, q);
    cmp("result", {1'b1, 9'h000, 6'd16, 16'h0020}, q);
    for (int m = 0; m < 2; m++)
    begin
      adv = m[0];
      bus(1, 5'h08, m, q);
      bus(0, 5'h08, 0, q);
      cmp("control", m, q);
      for (int i = 0; i < 25; i++)
        vec(25'h1 << i, 1, vnum(i));
    end
    for (int i = 1; i < 24; i++)
      vec(25'h3 << i, 1, vnum(i));
    vec(25'h1fffffe, 1, 6'd16);
    for (int k = 0; k < 5; k++)
    begin
      bus(1, 5'h00, {16'h0, lvl[k]}, q);
      vec(25'h1fffffe, 1, lwin[k]);
    end
    bus(1, 5'h00, 32'hffff, q);
    bus(0, 5'h00, 0, q);
    cmp("level", 32'hfe78, q);
    vec(25'h1fffffe, 1, 6'd16);
    bus(1, 5'h14, 0, q);
    bus(1, 5'h04, 0, q);
    vec(25'h1fffffe, 0, 0);
    vec(25'h1ffffff, 1, 6'd7);
    cmp("irq masked", 0, irq);
    bus(0, 5'h10, 0, q);
    cmp("status both", 3, q);
    cmp("taken", 7, taken.number);
    tally_and_finish();
  end
endmodule
